// File: verilog/switch_ctrl_defines.vh
// constants for the switch control memory and port activation block
`ifndef SWITCH_CTRL_DEFINES_VH
`define SWITCH_CTRL_DEFINES_VH

// ==========================================================
// register byte offsets
`define OFS_OP_MODE 8'h00
`define OFS_MEM_DATA 8'h04
`define OFS_MEM_ADDR 8'h08
`define OFS_MEM_CMD 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_PCM_BITNUM 8'h1C
`define OFS_SUB_BITNUM 8'h20
`define OFS_SUBCHAN 8'h24
`define OFS_PCM_DOWN_OFS 8'h28
`define OFS_SUB_CONFIG 8'h2C

// ==========================================================
// operation mode fields
`define OM_SEL_HI 7
`define OM_SEL_LO 6
`define OM_PCM_SBR 5
`define OM_TEST_LOOP 4
`define OM_OPEN_DRAIN 3
`define OM_MON_HS 2
`define OM_SUB_SBR 1
`define OM_BANK_SEL 0
`define MODE_MEM_RESET 2'b00
`define MODE_MEM_INIT 2'b10
`define MODE_NORMAL 2'b11

// ==========================================================
// status and interrupt bits
`define ST_BUSY 0
`define ST_SYNC 1
`define IRQ_FRAMING 0

// ==========================================================
// reset values
`define RST_OP_MODE 8'h00
`define RST_PCM_BITNUM 8'hFF
`define RST_SUB_BITNUM 8'hFF
`define RST_SUBCHAN 8'h00
`define RST_PCM_DOWN_OFS 8'h00

// ==========================================================
// memory commands and codes
`define CMD_GROUP 4'h7
`define CMD_FILL 8'h70
`define CODE_CODE_ONLY_EVEN 4'b0000
`define CODE_CODE_ONLY_ODD 4'b1011
`define CODE_DEC_MON 4'b1000
`define CODE_HDLC_EVEN 4'b1010
`define CODE_HDLC_ODD 4'b1011
`define CODE_FILL 4'b1111

// ==========================================================
// access timing counts in core clocks, down offset adjustment in pcm bits
`define ACCESS_CYC_NORMAL 8
`define ACCESS_CYC_INIT 3
`define DOWN_OFS_ADJ 10'd33

`endif

// File: verilog/switch_memory_and_port_activation.v
// time-slot switch control memory, mode control and port activation
//
// Operation
// - normal mode (11) enables the pcm framing interrupt source
// - matching pcm clock/frame raises framing irq if unmasked; sync bit 1
// - pcm output drivers enabled only while pcm standby release is 1
// - sub standby release activates interface, drivers, clock and sync outputs; clock and sync enables here also need sub config bit 0
// - output type select 1 gives open drain, 0 gives tristate
// - mode value EE gives normal, pcm active, open drain, sub active
// - writing 80 moves control memory from reset into init mode
// - in reset mode, data FF then command 70 fills whole memory
// - command 71 writes data and code 0001 at selected address
// - command 78 writes data and code 1000 at even upstream location
// - command 70 in normal access writes only code 0000
// - codes 1010/1011 mark downstream channels for hdlc controller a
// - address bit 7 set means upstream, clear downstream; low bits slot
// - pcm bit number FF gives a 512 bit pcm frame
// - sub bit number FF gives a 256 bit subscriber frame
// - subchannel value 00 puts 2-bit channels at bits 7 and 6
// - down offset F0 puts frame marker at second bit of frame
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "switch_ctrl_defines.vh"

module switch_memory_and_port_activation #(
	parameter NUM_SUB_PORTS = 4
) (
	input wire core_clk, // 100 MHz clock
	input wire resetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire pready, // apb ready
	output reg [31:0] prdata, // apb read data
	output reg pslverr, // apb error
	output wire irq, // level interrupt
	input wire pcm_clk_in, // pcm bit clock, sampled
	input wire pcm_frame_sync, // pcm frame sync, sampled
	input wire pcm_rxd, // pcm receive data
	output reg pcm_txd, // pcm transmit data
	output wire pcm_txd_en_n, // pcm driver enable, low drives
	output reg pcm_down_marker, // internal downstream frame marker
	input wire sub_rxd, // subscriber receive data
	output reg sub_txd, // subscriber transmit data
	output wire sub_txd_en_n, // subscriber driver enable, low drives
	output reg sub_data_clock, // subscriber data clock out
	output wire sub_data_clock_en_n, // its enable, low drives
	output reg sub_frame_sync, // subscriber frame sync out
	output wire sub_frame_sync_en_n, // its enable, low drives
	output wire [3*NUM_SUB_PORTS-1:0] subchan_msb, // channel msb per port
	output wire monitor_handshake_sel, // monitor handshake chosen
	output wire register_bank_sel, // register bank select
	input wire [7:0] mem_lookup_addr, // switching lookup address
	output reg [7:0] mem_lookup_data, // looked-up data
	output reg [3:0] mem_lookup_code, // looked-up code
	output reg hdlc_a_channel // lookup is an hdlc a channel
);

	// ==========================================================
	// reset release
	reg rst_meta;
	reg rst_n;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// registers
	reg [7:0] operation_mode_reg;
	reg [7:0] mem_data_reg;
	reg [7:0] mem_addr_reg;
	reg [7:0] mem_command_reg;
	reg [7:0] irq_status_reg;
	reg [7:0] irq_mask_reg;
	reg [7:0] pcm_bit_number_reg;
	reg [7:0] sub_bit_number_reg;
	reg [7:0] subchannel_reg;
	reg [7:0] pcm_down_offset_reg;
	reg [7:0] sub_config_reg;
	reg mem_access_busy;
	reg pcm_sync_status;
	reg framing_event;

	wire [1:0] op_mode_select = operation_mode_reg[`OM_SEL_HI:`OM_SEL_LO];
	wire pcm_standby_release = operation_mode_reg[`OM_PCM_SBR];
	wire pcm_test_loop = operation_mode_reg[`OM_TEST_LOOP];
	wire sub_output_type_sel = operation_mode_reg[`OM_OPEN_DRAIN];
	wire sub_if_standby_release = operation_mode_reg[`OM_SUB_SBR];
	wire normal_mode = (op_mode_select == `MODE_NORMAL);
	wire [7:0] status_reg = {6'd0, pcm_sync_status, mem_access_busy};

	assign monitor_handshake_sel = operation_mode_reg[`OM_MON_HS];
	assign register_bank_sel = operation_mode_reg[`OM_BANK_SEL];

	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `OFS_SUB_CONFIG);
		end
	endfunction

	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite && mapped(paddr);
	wire cmd_wr = wr && (paddr == `OFS_MEM_CMD);
	assign pready = 1'b1;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			operation_mode_reg <= `RST_OP_MODE;
			mem_data_reg <= 8'h00;
			mem_addr_reg <= 8'h00;
			mem_command_reg <= 8'h00;
			irq_mask_reg <= 8'h00;
			pcm_bit_number_reg <= `RST_PCM_BITNUM;
			sub_bit_number_reg <= `RST_SUB_BITNUM;
			subchannel_reg <= `RST_SUBCHAN;
			pcm_down_offset_reg <= `RST_PCM_DOWN_OFS;
			sub_config_reg <= 8'h00;
		end else if (wr) begin
			case (paddr)
			`OFS_OP_MODE: operation_mode_reg <= pwdata[7:0];
			`OFS_MEM_DATA: mem_data_reg <= pwdata[7:0];
			`OFS_MEM_ADDR: mem_addr_reg <= pwdata[7:0];
			`OFS_MEM_CMD: mem_command_reg <= pwdata[7:0];
			`OFS_IRQ_MASK: irq_mask_reg <= pwdata[7:0];
			`OFS_PCM_BITNUM: pcm_bit_number_reg <= pwdata[7:0];
			`OFS_SUB_BITNUM: sub_bit_number_reg <= pwdata[7:0];
			`OFS_SUBCHAN: subchannel_reg <= pwdata[7:0];
			`OFS_PCM_DOWN_OFS: pcm_down_offset_reg <= pwdata[7:0];
			`OFS_SUB_CONFIG: sub_config_reg <= pwdata[7:0];
			default: ;
			endcase
		end
	end

	// read data and error captured in the setup phase
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= !mapped(paddr);
			case (paddr)
			`OFS_OP_MODE: prdata <= {24'd0, operation_mode_reg};
			`OFS_MEM_DATA: prdata <= {24'd0, mem_data_reg};
			`OFS_MEM_ADDR: prdata <= {24'd0, mem_addr_reg};
			`OFS_MEM_CMD: prdata <= {24'd0, mem_command_reg};
			`OFS_STATUS: prdata <= {24'd0, status_reg};
			`OFS_IRQ_STATUS: prdata <= {24'd0, irq_status_reg};
			`OFS_IRQ_MASK: prdata <= {24'd0, irq_mask_reg};
			`OFS_PCM_BITNUM: prdata <= {24'd0, pcm_bit_number_reg};
			`OFS_SUB_BITNUM: prdata <= {24'd0, sub_bit_number_reg};
			`OFS_SUBCHAN: prdata <= {24'd0, subchannel_reg};
			`OFS_PCM_DOWN_OFS: prdata <= {24'd0, pcm_down_offset_reg};
			`OFS_SUB_CONFIG: prdata <= {24'd0, sub_config_reg};
			default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// interrupt status, set wins over write-one clear
	wire [7:0] irq_set = {7'd0, framing_event};
	wire [7:0] irq_clr = (wr && paddr == `OFS_IRQ_STATUS) ?
		pwdata[7:0] : 8'h00;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			irq_status_reg <= 8'h00;
		else
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
	end
	assign irq = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// pcm frame check
	reg pclk_prev;
	reg fs_prev;
	reg [9:0] pcm_bit_cnt;
	wire pclk_rise = pcm_clk_in && !pclk_prev;
	wire fs_rise = pclk_rise && pcm_frame_sync && !fs_prev;
	// frame length is twice bit number plus two
	wire [9:0] pcm_frame_len = {1'b0, pcm_bit_number_reg, 1'b0} + 10'd2;
	// marker bit position from offset register
	wire [9:0] down_mark =
		({1'b0, pcm_down_offset_reg, 1'b0} + `DOWN_OFS_ADJ) &
		({1'b0, pcm_bit_number_reg, 1'b1});
	wire frame_ok = (pcm_bit_cnt + 10'd1 == pcm_frame_len);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pclk_prev <= 1'b0;
			fs_prev <= 1'b0;
			pcm_bit_cnt <= 10'd0;
			pcm_sync_status <= 1'b0;
			framing_event <= 1'b0;
			pcm_down_marker <= 1'b0;
			pcm_txd <= 1'b1;
		end else begin
			pclk_prev <= pcm_clk_in;
			framing_event <= 1'b0;
			pcm_down_marker <= 1'b0;
			if (pclk_rise) begin
				fs_prev <= pcm_frame_sync;
				pcm_txd <= pcm_test_loop ? pcm_rxd : 1'b1;
				if (fs_rise) begin
					pcm_bit_cnt <= 10'd0;
					pcm_sync_status <= frame_ok;
					// source active in normal mode only
					if (normal_mode && frame_ok != pcm_sync_status)
						framing_event <= 1'b1;
				end else begin
					pcm_bit_cnt <= pcm_bit_cnt + 10'd1;
				end
				if ((fs_rise ? 10'd0 : pcm_bit_cnt + 10'd1) == down_mark)
					pcm_down_marker <= 1'b1;
			end
		end
	end
	assign pcm_txd_en_n = !pcm_standby_release;

	// ==========================================================
	// subscriber side framing and drivers
	reg [8:0] sub_bit_cnt;
	// frame length is bit number plus one
	wire [8:0] sub_frame_len = {1'b0, sub_bit_number_reg} + 9'd1;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_bit_cnt <= 9'd0;
			sub_frame_sync <= 1'b0;
			sub_data_clock <= 1'b0;
			sub_txd <= 1'b1;
		end else begin
			sub_data_clock <= pcm_clk_in;
			if (pclk_rise) begin
				sub_txd <= sub_rxd;
				sub_frame_sync <= (sub_bit_cnt == 9'd0);
				if (sub_bit_cnt + 9'd1 == sub_frame_len)
					sub_bit_cnt <= 9'd0;
				else
					sub_bit_cnt <= sub_bit_cnt + 9'd1;
			end
		end
	end
	// activation gates drivers and clock outputs
	wire sub_clk_out = sub_if_standby_release && sub_config_reg[0];
	assign sub_data_clock_en_n = !sub_clk_out;
	assign sub_frame_sync_en_n = !sub_clk_out;
	assign sub_txd_en_n = !(sub_if_standby_release &&
		(!sub_output_type_sel || !sub_txd));

	// two bits per port select channel msb
	genvar gp;
	generate
		for (gp = 0; gp < NUM_SUB_PORTS; gp = gp + 1) begin : g_sub
			assign subchan_msb[3*gp +: 3] =
				3'd7 - {subchannel_reg[2*gp +: 2], 1'b0};
		end
	endgenerate

	// ==========================================================
	// control memory access engine
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_FILL = 3'b100;

	reg [7:0] ctl_data [0:255];
	reg [3:0] ctl_code [0:255];
	reg [2:0] state;
	reg [2:0] next_state;
	reg [7:0] acc_cnt;
	reg [7:0] fill_idx;
	reg [7:0] acc_addr;
	reg [7:0] acc_data;
	reg [3:0] acc_code;
	reg acc_wdata;

	function writes_data;
		input [3:0] code;
		begin
			writes_data = (code != `CODE_CODE_ONLY_EVEN) &&
				(code != `CODE_CODE_ONLY_ODD);
		end
	endfunction

	wire cmd_group = (pwdata[7:4] == `CMD_GROUP);
	wire cmd_fill = (op_mode_select == `MODE_MEM_RESET) &&
		(pwdata[7:0] == `CMD_FILL);
	// decentral code only at even upstream slot
	wire cmd_bad = (pwdata[3:0] == `CODE_DEC_MON) &&
		(!mem_addr_reg[7] || mem_addr_reg[0]);
	wire cmd_take = cmd_wr && cmd_group && !cmd_bad && !mem_access_busy;
	wire acc_done = (state == ST_WAIT) && (acc_cnt == 8'd0);
	wire fill_done = (state == ST_FILL) && (fill_idx == 8'hFF);

	always @* begin
		case (state)
		ST_IDLE: next_state = cmd_take ?
			(cmd_fill ? ST_FILL : ST_WAIT) : ST_IDLE;
		ST_WAIT: next_state = acc_done ? ST_IDLE : ST_WAIT;
		ST_FILL: next_state = fill_done ? ST_IDLE : ST_FILL;
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			mem_access_busy <= 1'b0;
			acc_cnt <= 8'd0;
			fill_idx <= 8'd0;
			acc_addr <= 8'd0;
			acc_data <= 8'd0;
			acc_code <= 4'd0;
			acc_wdata <= 1'b0;
		end else begin
			state <= next_state;
			// busy from acceptance to end of access
			mem_access_busy <= (next_state != ST_IDLE);
			if (state == ST_IDLE && cmd_take) begin
				// address bit 7 picks direction half
				acc_addr <= mem_addr_reg;
				acc_data <= mem_data_reg;
				acc_code <= pwdata[3:0];
				acc_wdata <= writes_data(pwdata[3:0]);
				fill_idx <= 8'd0;
				acc_cnt <= normal_mode ? 8'd`ACCESS_CYC_NORMAL - 8'd1 :
					8'd`ACCESS_CYC_INIT - 8'd1;
			end else if (state == ST_WAIT && acc_cnt != 8'd0) begin
				acc_cnt <= acc_cnt - 8'd1;
			end else if (state == ST_FILL) begin
				fill_idx <= fill_idx + 8'd1;
			end
		end
	end

	// memory array has no reset
	always @(posedge core_clk) begin
		if (state == ST_FILL) begin
			// fill every location with data register
			ctl_data[fill_idx] <= acc_data;
			ctl_code[fill_idx] <= `CODE_FILL;
		end else if (acc_done) begin
			// data only where command carries it
			if (acc_wdata)
				ctl_data[acc_addr] <= acc_data;
			ctl_code[acc_addr] <= acc_code;
		end
		mem_lookup_data <= ctl_data[mem_lookup_addr];
		mem_lookup_code <= ctl_code[mem_lookup_addr];
	end

	// downstream hdlc a channel pair codes
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			hdlc_a_channel <= 1'b0;
		else
			hdlc_a_channel <= !mem_lookup_addr[7] &&
				(ctl_code[mem_lookup_addr] == `CODE_HDLC_EVEN ||
				ctl_code[mem_lookup_addr] == `CODE_HDLC_ODD);
	end

endmodule
`default_nettype wire

// File: tb/switch_ctrl_checker_assertions.sv
// concurrent checks on the switch control block ports
`timescale 1ns/1ns
`default_nettype none
`include "switch_ctrl_defines.vh"
module switch_ctrl_checker (
	input wire logic core_clk, // clock
	input wire logic resetn, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic irq, // interrupt
	input wire logic pcm_txd_en_n, // pcm drive
	input wire logic sub_txd, // sub data
	input wire logic sub_txd_en_n, // sub drive
	input wire logic sub_data_clock_en_n, // clock drive
	input wire logic monitor_handshake_sel, // handshake
	input wire logic register_bank_sel, // bank
	input wire logic [7:0] mem_lookup_addr, // lookup addr
	input wire logic [3:0] mem_lookup_code, // lookup code
	input wire logic hdlc_a_channel // hdlc lookup
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] mode, cfg, ma;
	logic [8:0] cnt;
	logic msk;
	wire wr = psel && penable && pwrite;
	wire rds = psel && penable && !pwrite && paddr == `OFS_STATUS;
	wire dm = pwdata[3:0] == `CODE_DEC_MON && (!ma[7] || ma[0]);
	wire cmd = wr && paddr == `OFS_MEM_CMD && pwdata[7:4] == `CMD_GROUP;
	wire go = cmd && cnt == 9'h000 && !dm;
	wire fill = mode[7:6] == `MODE_MEM_RESET && pwdata[7:0] == `CMD_FILL;
	// ==========
	// shadows of written registers and busy span
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode <= `RST_OP_MODE;
			cfg <= 8'h00;
			ma <= 8'h00;
			msk <= 1'b0;
			cnt <= 9'h000;
		end else begin
			if (wr && paddr == `OFS_OP_MODE) mode <= pwdata[7:0];
			if (wr && paddr == `OFS_SUB_CONFIG) cfg <= pwdata[7:0];
			if (wr && paddr == `OFS_MEM_ADDR) ma <= pwdata[7:0];
			if (wr && paddr == `OFS_IRQ_MASK) msk <= pwdata[0];
			if (go && mode[7:6] == `MODE_NORMAL) cnt <= 9'(`ACCESS_CYC_NORMAL);
			else if (go && fill) cnt <= 9'h100;
			else if (go) cnt <= 9'(`ACCESS_CYC_INIT);
			else if (cnt != 9'h000) cnt <= cnt - 9'h001;
		end
	end
	// ==========
	// properties
	property p_pcm_drv; pcm_txd_en_n == !mode[`OM_PCM_SBR]; endproperty
	a_pcm_drv: assert property (p_pcm_drv) else $error("pcm drive");
	property p_sub_drv;
		sub_txd_en_n ==
			!(mode[`OM_SUB_SBR] && (!mode[`OM_OPEN_DRAIN] || !sub_txd));
	endproperty
	a_sub_drv: assert property (p_sub_drv) else $error("sub drive");
	property p_clk_drv;
		sub_data_clock_en_n == !(mode[`OM_SUB_SBR] && cfg[0]);
	endproperty
	a_clk_drv: assert property (p_clk_drv) else $error("clock drive");
	property p_sel;
		{monitor_handshake_sel, register_bank_sel} ==
			{mode[`OM_MON_HS], mode[`OM_BANK_SEL]};
	endproperty
	a_sel: assert property (p_sel) else $error("mode outputs");
	property p_busy; rds && cnt > 9'h001 |-> prdata[`ST_BUSY]; endproperty
	a_busy: assert property (p_busy) else $error("busy low");
	property p_idle;
		rds && cnt == 9'h000 && $past(cnt) == 9'h000 |-> !prdata[`ST_BUSY];
	endproperty
	a_idle: assert property (p_idle) else $error("busy stuck");
	property p_irq_src; $rose(irq) |-> msk && mode[7:6] == `MODE_NORMAL; endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq source");
	property p_irq_clr; wr && paddr == `OFS_IRQ_STATUS && pwdata[0] |=> !irq; endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
	property p_irq_mask; wr && paddr == `OFS_IRQ_MASK && !pwdata[0] |=> !irq; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq mask");
	property p_hdlc;
		mem_lookup_code[3:1] == 3'b101 |->
			hdlc_a_channel == !$past(mem_lookup_addr[7]);
	endproperty
	a_hdlc: assert property (p_hdlc) else $error("hdlc flag");
	c_go: cover property (go);
	c_irq: cover property ($rose(irq));
	c_hdlc: cover property (hdlc_a_channel);
endmodule
`default_nettype wire

// File: tb/pcm_far_end.sv
// far-end pcm framer model feeding the switch block
`timescale 1ns/1ns
`default_nettype none
module pcm_far_end (
	input wire logic core_clk, // clock
	input wire logic good, // nominal frames
	output logic pcm_clk_in, // bit clock
	output var logic pcm_frame_sync = 1'b0, // frame start
	output var logic pcm_rxd = 1'b0 // line data
);
	logic [1:0] div = 2'h0;
	logic [9:0] bitc = 10'h000;
	wire [9:0] last = good ? 10'h1FF : 10'h1F3;
	assign pcm_clk_in = div[1];
	always @(posedge core_clk) begin
		div <= div + 2'h1;
		if (div == 2'h3) begin
			bitc <= bitc >= last ? 10'h000 : bitc + 10'h001;
			pcm_frame_sync <= bitc >= last;
			pcm_rxd <= ~pcm_rxd;
		end
	end
endmodule
`default_nettype wire

// File: tb/switch_memory_and_port_activation_tb.sv
// self-checking bench for the switch control block
`timescale 1ns/1ns
`default_nettype none
`include "switch_ctrl_defines.vh"
module switch_memory_and_port_activation_tb;
	logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic pcm_clk_in, pcm_frame_sync, pcm_rxd, pcm_txd, pcm_txd_en_n, good;
	logic pcm_down_marker, sub_rxd, sub_txd, sub_txd_en_n, sub_data_clock;
	logic sub_data_clock_en_n, sub_frame_sync, sub_frame_sync_en_n;
	logic monitor_handshake_sel, register_bank_sel, hdlc_a_channel;
	logic [7:0] paddr, mem_lookup_addr, mem_lookup_data;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] subchan_msb;
	logic [3:0] mem_lookup_code;
	int miscompares, check_count, marks;
	switch_memory_and_port_activation switch_memory_and_port_activation_i (
		.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .irq, .pcm_clk_in, .pcm_frame_sync,
		.pcm_rxd, .pcm_txd, .pcm_txd_en_n, .pcm_down_marker, .sub_rxd,
		.sub_txd, .sub_txd_en_n, .sub_data_clock, .sub_data_clock_en_n,
		.sub_frame_sync, .sub_frame_sync_en_n, .subchan_msb,
		.monitor_handshake_sel, .register_bank_sel, .mem_lookup_addr,
		.mem_lookup_data, .mem_lookup_code, .hdlc_a_channel
	);
	pcm_far_end pcm_far_end_i (
		.core_clk, .good, .pcm_clk_in, .pcm_frame_sync, .pcm_rxd
	);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input string n, input logic [7:0] g, e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task flag(input string n, input logic g, e);
		chk(n, {7'h00, g}, {7'h00, e});
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task wr(input logic [7:0] a, d);
		apb(1'b1, a, d);
	endtask
	task rdc(input string n, input logic [7:0] a, e);
		apb(1'b0, a, 8'h00);
		chk(n, rd[7:0], e);
	endtask
	task mem(input logic [7:0] d, a, c);
		wr(`OFS_MEM_DATA, d);
		wr(`OFS_MEM_ADDR, a);
		wr(`OFS_MEM_CMD, c);
		rdc("busy", `OFS_STATUS, 8'h01);
		repeat (300) begin
			if (rd[`ST_BUSY] === 1'b0) break;
			apb(1'b0, `OFS_STATUS, 8'h00);
		end
		chk("idle", rd[7:0], 8'h00);
	endtask
	task look(input logic [7:0] a, d, input logic [3:0] c);
		@(posedge core_clk);
		mem_lookup_addr <= a;
		repeat (2) @(posedge core_clk);
		#1;
		chk("ldata", mem_lookup_data, d);
		chk("lcode", {4'h0, mem_lookup_code}, {4'h0, c});
		flag("hdlc", hdlc_a_channel, !a[7] && c[3:1] == 3'b101);
	endtask
	task t_regs;
		rdc("pbn", `OFS_PCM_BITNUM, 8'hFF);
		rdc("sbn", `OFS_SUB_BITNUM, 8'hFF);
		rdc("sch", `OFS_SUBCHAN, 8'h00);
		chk("msb", subchan_msb[7:0], 8'hFF);
		chk("msb1", {4'h0, subchan_msb[11:8]}, 8'h0F);
		rdc("gap", 8'h30, 8'h00);
		flag("err", err, 1'b1);
		wr(`OFS_PCM_DOWN_OFS, 8'hF0);
		rdc("pcm_down_offset_reg", `OFS_PCM_DOWN_OFS, 8'hF0);
	endtask
	task t_fill;
		mem(8'hFF, 8'h00, `CMD_FILL);
		look(8'h00, 8'hFF, `CODE_FILL);
		look(8'hFF, 8'hFF, `CODE_FILL);
	endtask
	task t_init;
		wr(`OFS_OP_MODE, 8'h80);
		mem(8'h89, 8'h80, 8'h71);
		mem(8'h01, 8'h01, 8'h71);
		look(8'h80, 8'h89, 4'b0001);
		look(8'h01, 8'h01, 4'b0001);
		mem(8'hFF, 8'h88, 8'h78);
		mem(8'h12, 8'h89, 8'h71);
		mem(8'h34, 8'h89, `CMD_FILL);
		look(8'h88, 8'hFF, `CODE_DEC_MON);
		look(8'h89, 8'h12, 4'b0000);
		wr(`OFS_MEM_CMD, 8'h78);
		rdc("odd78", `OFS_STATUS, 8'h00);
		look(8'h89, 8'h12, 4'b0000);
		mem(8'hF3, 8'h08, 8'h7A);
		mem(8'h55, 8'h09, 8'h7B);
		look(8'h08, 8'hF3, 4'b1010);
		look(8'h09, 8'hFF, 4'b1011);
	endtask
	task t_active;
		wr(`OFS_SUB_CONFIG, 8'h01);
		flag("pdrv", pcm_txd_en_n, 1'b1);
		flag("cdrv", sub_data_clock_en_n, 1'b1);
		wr(`OFS_OP_MODE, 8'hEE);
		flag("pdrv", pcm_txd_en_n, 1'b0);
		flag("cdrv", sub_data_clock_en_n, 1'b0);
		flag("fdrv", sub_frame_sync_en_n, 1'b0);
		flag("mhs", monitor_handshake_sel, 1'b1);
		flag("rbs", register_bank_sel, 1'b0);
		flag("od0", sub_txd_en_n, 1'b0);
		@(posedge core_clk);
		sub_rxd <= 1'b1;
		repeat (20) @(posedge core_clk);
		#1;
		flag("od1", sub_txd_en_n, 1'b1);
		wr(`OFS_OP_MODE, 8'hE6);
		flag("ts", sub_txd_en_n, 1'b0);
		wr(`OFS_OP_MODE, 8'hEE);
	endtask
	task t_sync;
		@(posedge core_clk);
		good <= 1'b1;
		repeat (300) begin
			apb(1'b0, `OFS_STATUS, 8'h00);
			if (rd[`ST_SYNC] === 1'b1) break;
			repeat (40) @(posedge core_clk);
		end
		flag("sync", rd[`ST_SYNC], 1'b1);
		flag("irq0", irq, 1'b0);
		rdc("irq_status_reg", `OFS_IRQ_STATUS, 8'h01);
		wr(`OFS_IRQ_MASK, 8'h01);
		flag("irq1", irq, 1'b1);
		wr(`OFS_IRQ_STATUS, 8'h01);
		flag("irqc", irq, 1'b0);
		flag("ptxd", pcm_txd, 1'b1);
		marks = 0;
		// one marker pulse per 512 bit frame
		repeat (2048) begin
			@(posedge core_clk);
			#1;
			if (pcm_down_marker === 1'b1) marks++;
		end
		chk("marker", marks[7:0], 8'h01);
	endtask
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		sub_rxd = 1'b0;
		good = 1'b0;
		mem_lookup_addr = 8'h00;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs;
		t_fill;
		t_init;
		t_active;
		t_sync;
		wrap_up;
	end
	initial begin
		#500000;
		miscompares++;
		wrap_up;
	end
endmodule
bind switch_memory_and_port_activation switch_ctrl_checker switch_ctrl_checker_i (
	.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.irq, .pcm_txd_en_n, .sub_txd, .sub_txd_en_n, .sub_data_clock_en_n,
	.monitor_handshake_sel, .register_bank_sel, .mem_lookup_addr,
	.mem_lookup_code, .hdlc_a_channel
);
`default_nettype wire
